// >>> src/irq_ctrl_pkg.sv
// shared constants, types and bus structs of the interrupt controller
package irq_ctrl_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_IRQ = 30;
	localparam int PRIO_W = 4;
	localparam int ID_W = 5;
	localparam int NUM_PRIO_REGS = 8;
	localparam int GROUP_W = 3;

	// ==========================================================
	// register byte addresses on the core private bus
	localparam logic [31:0] ADDR_ENABLE_SET = 32'hE000E100;
	localparam logic [31:0] ADDR_ENABLE_CLEAR = 32'hE000E180;
	localparam logic [31:0] ADDR_PENDING_SET = 32'hE000E200;
	localparam logic [31:0] ADDR_PENDING_CLEAR = 32'hE000E280;
	localparam logic [31:0] ADDR_ACTIVE_STATUS = 32'hE000E300;
	localparam logic [31:0] ADDR_PRIO_BASE = 32'hE000E400;
	localparam logic [31:0] ADDR_PRIO_LAST = 32'hE000E41C;
	localparam logic [31:0] ADDR_SOFT_TRIGGER = 32'hE000EF00;

	// ==========================================================
	// field layouts and reset values
	localparam logic [31:0] IRQ_BITS_MASK = 32'h3FFFFFFF;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [3:0] PRIO_RESET = 4'h0;
	localparam logic [3:0] PRIO_LOWEST = 4'hF;
	localparam logic [2:0] GROUP_RESET = 3'h0;
	localparam logic [8:0] SOFT_ID_MASK = 9'h1FF;
	localparam int FIELDS_PER_REG = 4;
	localparam int FIELD_STRIDE = 8;

	// ==========================================================
	// bus carrier and core-side answer
	typedef struct packed {
		logic sel;
		logic write;
		logic priv;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic valid;
		logic [ID_W-1:0] id;
		logic [PRIO_W-1:0] prio;
	} irq_pick_t;

	typedef enum logic [1:0] {
		CORE_IDLE = 2'b00,
		CORE_TAKE = 2'b01,
		CORE_BUSY = 2'b11
	} core_state_t;

endpackage

// >>> src/irq_prio_pick.sv
// priority pick over enabled pending interrupts
`timescale 1ns/10ps
module irq_prio_pick
	import irq_ctrl_pkg::*;
(
	input wire logic [NUM_IRQ-1:0] cand,
	input wire logic [NUM_IRQ*PRIO_W-1:0] prio,
	input wire logic [GROUP_W-1:0] group_sel,
	output irq_pick_t pick
);

	// group part of a level: bits above the subpriority split
	function automatic logic [PRIO_W-1:0] group_of(
		input logic [PRIO_W-1:0] p,
		input logic [GROUP_W-1:0] g
	);
		logic [PRIO_W-1:0] m;
		m = PRIO_LOWEST << g;
		return p & m;
	endfunction

	// ==========================================================
	// scan
	// lower level wins
	// lowest group wins, then lowest full level, then lowest number
	always_comb begin
		logic [PRIO_W-1:0] p;
		p = PRIO_RESET;
		pick = '0;
		for (int i = 0; i < NUM_IRQ; i++) begin
			p = prio[i*PRIO_W +: PRIO_W];
			if (cand[i] && (!pick.valid ||
				group_of(p, group_sel) < group_of(pick.prio, group_sel) ||
				(group_of(p, group_sel) == group_of(pick.prio, group_sel)
				&& p < pick.prio))) begin
				pick.valid = 1'b1;
				pick.id = ID_W'(i);
				pick.prio = p;
			end
		end
	end

endmodule

// >>> src/irq_enable_pending_bank.sv
// interrupt enable, pending, active and priority bank with core handshake
//
// Function
// - Registers decode at 0xE000E100 bank and the separate 0xE000EF00 word.
// - Each interrupt has priority 0-15; zero is most urgent.
// - Request lines are sensed by level, not edge.
// - Priority writes take effect in arbitration at once.
// - Priority splits into group and subpriority for arbitration.
// - Enable, pending, active each one 32-bit word, interrupt n at bit n.
// - Eight priority words hold 4-bit fields in ascending interrupt order.
// - Enable-set: one enables, zero ignored, read gives enable state.
// - Enable-clear: one disables, zero ignored, read gives enable state.
// - Pending-set: one makes pending, zero ignored, read gives pending.
// - Setting an already pending interrupt leaves it unchanged.
// - Pending-set on a disabled interrupt still makes it pending.
// - Pending and enabled interrupts become active by priority.
// - Disabled interrupts may pend but never become active.
// - Register accesses take effect only for privileged transactions.
// - Pending-clear: one removes pending, zero ignored, read gives pending.
// - Clearing pending leaves the active state untouched.
// - Active bit reads one when active, also while active and pending.
`timescale 1ns/10ps
module irq_enable_pending_bank
	import irq_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [NUM_IRQ-1:0] irq_req,
	input wire logic bus_sel,
	input wire logic bus_write,
	input wire logic bus_priv,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic [GROUP_W-1:0] group_sel,
	input wire logic core_ack,
	input wire logic core_done,
	output logic [31:0] bus_rdata,
	output logic bus_hit,
	output logic irq_take,
	output logic [ID_W-1:0] irq_id,
	output logic [PRIO_W-1:0] irq_prio
);

	// whole state of the block
	// one bit per line in enable, pending and active; PRIO_W bits per line in prio
	typedef struct packed {
		logic [NUM_IRQ-1:0] enable;
		logic [NUM_IRQ-1:0] pending;
		logic [NUM_IRQ-1:0] active;
		logic [NUM_IRQ*PRIO_W-1:0] prio;
		core_state_t core;
		logic [ID_W-1:0] cur_id;
		logic [PRIO_W-1:0] cur_prio;
		logic take;
		logic [31:0] rdata;
		logic hit;
	} state_t;

	state_t st_q;
	state_t st_d;
	bus_req_t req;
	irq_pick_t pick;
	logic [NUM_IRQ-1:0] cand;

	// one-hot mask of an interrupt number, clipped to real lines
	function automatic logic [NUM_IRQ-1:0] irq_bit(input logic [ID_W-1:0] n);
		return NUM_IRQ'(1) << n;
	endfunction

	// priority word m gathers fields 4m..4m+3, one per byte lane
	function automatic logic [31:0] prio_word(
		input logic [NUM_IRQ*PRIO_W-1:0] p,
		input logic [2:0] m
	);
		logic [31:0] w;
		int n;
		w = RESET_WORD;
		for (int k = 0; k < FIELDS_PER_REG; k++) begin
			n = int'(m) * FIELDS_PER_REG + k;
			if (n < NUM_IRQ)
				w[k*FIELD_STRIDE +: PRIO_W] = p[n*PRIO_W +: PRIO_W];
		end
		return w;
	endfunction

	assign req = '{sel: bus_sel, write: bus_write, priv: bus_priv,
		addr: bus_addr, wdata: bus_wdata};

	// ==========================================================
	// arbitration
	// active by priority
	assign cand = st_q.pending & st_q.enable & ~st_q.active;

	irq_prio_pick u_pick (
		.cand(cand),
		.prio(st_q.prio),
		.group_sel(group_sel),
		.pick(pick)
	);

	// ==========================================================
	// next state
	always_comb begin
		logic [31:0] w;
		logic [2:0] idx;
		logic acc;
		w = req.wdata & IRQ_BITS_MASK;
		idx = req.addr[4:2];
		acc = req.sel && req.priv;
		st_d = st_q;
		st_d.take = 1'b0;
		st_d.hit = 1'b0;
		st_d.rdata = RESET_WORD;

		// level sensing
		// a held request keeps re-pending after a clear
		st_d.pending = st_q.pending | irq_req;

		if (acc && req.write) begin
			case (req.addr)
				ADDR_ENABLE_SET: begin
					st_d.enable = st_q.enable | w[NUM_IRQ-1:0];
					st_d.hit = 1'b1;
				end
				ADDR_ENABLE_CLEAR: begin
					st_d.enable = st_q.enable & ~w[NUM_IRQ-1:0];
					st_d.hit = 1'b1;
				end
				ADDR_PENDING_SET: begin
					st_d.pending = st_d.pending | w[NUM_IRQ-1:0];
					st_d.hit = 1'b1;
				end
				// pending clear; a live line wins over it
				ADDR_PENDING_CLEAR: begin
					st_d.pending = (st_q.pending & ~w[NUM_IRQ-1:0]) | irq_req;
					st_d.hit = 1'b1;
				end
				// separate trigger word sets one pending bit
				ADDR_SOFT_TRIGGER: begin
					if ((req.wdata[8:0] & SOFT_ID_MASK) < 9'(NUM_IRQ))
						st_d.pending = st_d.pending |
							irq_bit(req.wdata[ID_W-1:0]);
					st_d.hit = 1'b1;
				end
				default: begin
					// priority words, one field per byte
					if (req.addr >= ADDR_PRIO_BASE &&
						req.addr <= ADDR_PRIO_LAST &&
						req.addr[1:0] == 2'b00) begin
						for (int k = 0; k < FIELDS_PER_REG; k++) begin
							if (int'(idx) * FIELDS_PER_REG + k < NUM_IRQ)
								st_d.prio[(int'(idx) * FIELDS_PER_REG + k)
									* PRIO_W +: PRIO_W] =
									req.wdata[k*FIELD_STRIDE +: PRIO_W];
						end
						st_d.hit = 1'b1;
					end
				end
			endcase
		end else if (acc) begin
			st_d.hit = 1'b1;
			case (req.addr)
				ADDR_ENABLE_SET,
				ADDR_ENABLE_CLEAR:
					st_d.rdata = 32'(st_q.enable);
				ADDR_PENDING_SET,
				ADDR_PENDING_CLEAR:
					st_d.rdata = 32'(st_q.pending);
				ADDR_ACTIVE_STATUS:
					st_d.rdata = 32'(st_q.active);
				default: begin
					if (req.addr >= ADDR_PRIO_BASE &&
						req.addr <= ADDR_PRIO_LAST &&
						req.addr[1:0] == 2'b00)
						st_d.rdata = prio_word(st_q.prio, idx);
					else
						st_d.hit = 1'b0;
				end
			endcase
		end

		// ==========================================================
		// core handshake: offer, take on ack, retire on done
		case (st_q.core)
			CORE_IDLE: begin
				// offer best candidate
				// a disable landing in this same cycle holds the offer back
				if (pick.valid && st_d.enable[pick.id]) begin
					st_d.core = CORE_TAKE;
					st_d.cur_id = pick.id;
					st_d.cur_prio = pick.prio;
					st_d.take = 1'b1;
				end
			end
			CORE_TAKE: begin
				st_d.take = 1'b1;
				// withdraw if disabled or cleared meanwhile
				// judged on the updated state so a same-cycle disable wins
				if (!(st_d.enable[st_q.cur_id] && st_d.pending[st_q.cur_id]))
					st_d.core = CORE_IDLE;
				else if (core_ack) begin
					st_d.core = CORE_BUSY;
					st_d.take = 1'b0;
					st_d.active = st_q.active | irq_bit(st_q.cur_id);
					// taking it clears pending unless the line is high
					st_d.pending = (st_d.pending & ~irq_bit(st_q.cur_id))
						| irq_req;
				end else if (pick.valid && pick.id != st_q.cur_id &&
					st_d.enable[pick.id]) begin
					// a re-prioritised winner replaces the offer
					st_d.cur_id = pick.id;
					st_d.cur_prio = pick.prio;
				end
			end
			CORE_BUSY: begin
				// only the handler's end clears active
				if (core_done) begin
					st_d.active = st_q.active & ~irq_bit(st_q.cur_id);
					st_d.core = CORE_IDLE;
				end
			end
			default: st_d.core = CORE_IDLE;
		endcase
		if (st_d.core != CORE_TAKE)
			st_d.take = 1'b0;
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
			st_q.core <= CORE_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus_rdata = st_q.rdata;
	assign bus_hit = st_q.hit;
	assign irq_take = st_q.take;
	assign irq_id = st_q.cur_id;
	assign irq_prio = st_q.cur_prio;

	// ==========================================================
	// checks
	sequence s_enable_write;
		bus_sel && bus_priv && bus_write && bus_addr == ADDR_ENABLE_SET;
	endsequence

	a_enable_set_sticks: assert property (@(posedge clk) disable iff (!resetn)
		s_enable_write |=> ((st_q.enable
			& $past(bus_wdata[NUM_IRQ-1:0])) == $past(bus_wdata[NUM_IRQ-1:0])))
		else $error("enable set bit did not stick");

	a_enable_clear_drops: assert property (@(posedge clk) disable iff (!resetn)
		(bus_sel && bus_priv && bus_write && bus_addr == ADDR_ENABLE_CLEAR)
		|=> ((st_q.enable & $past(bus_wdata[NUM_IRQ-1:0])) == '0))
		else $error("enable clear left a bit set");

	a_pending_set_sticks: assert property (@(posedge clk) disable iff (!resetn)
		(bus_sel && bus_priv && bus_write && bus_addr == ADDR_PENDING_SET)
		|=> ((~st_q.pending & $past(bus_wdata[NUM_IRQ-1:0])
			& ~(st_q.active)) == '0 || st_q.core == CORE_BUSY))
		else $error("pending set missed");

	a_unpriv_ignored: assert property (@(posedge clk) disable iff (!resetn)
		(bus_sel && !bus_priv) |=> !bus_hit)
		else $error("unprivileged access answered");

	a_offer_enabled: assert property (@(posedge clk) disable iff (!resetn)
		irq_take |-> st_q.enable[st_q.cur_id])
		else $error("offer of disabled interrupt");

	a_high_bits_zero: assert property (@(posedge clk) disable iff (!resetn)
		bus_hit |-> bus_rdata[31:NUM_IRQ] == '0)
		else $error("reserved bits read non-zero");

	a_level_pends: assert property (@(posedge clk) disable iff (!resetn)
		irq_req[0] |=> st_q.pending[0] || st_q.active[0])
		else $error("level request not pending");

	a_clear_keeps_active: assert property (@(posedge clk) disable iff (!resetn)
		(bus_sel && bus_priv && bus_write && bus_addr == ADDR_PENDING_CLEAR
		&& !core_done) |=> (st_q.active & $past(st_q.active)) == $past(st_q.active))
		else $error("pending clear hit active state");

	// a write in the same cycle may disable the winner, so it is left out
	a_offer_in_time: assert property (@(posedge clk) disable iff (!resetn)
		(st_q.core == CORE_IDLE && cand != '0 && !(bus_sel && bus_write))
		|=> irq_take)
		else $error("candidate not offered");

	// first priority field follows a privileged write at once
	sequence s_prio0_write;
		bus_sel && bus_priv && bus_write && bus_addr == ADDR_PRIO_BASE;
	endsequence

	a_prio_write_lands: assert property (@(posedge clk) disable iff (!resetn)
		s_prio0_write |=> st_q.prio[PRIO_W-1:0] == $past(bus_wdata[PRIO_W-1:0]))
		else $error("priority write did not land");

	// a cleared bit stays clear unless its line was still high
	a_pending_clear_drops: assert property (@(posedge clk) disable iff (!resetn)
		(bus_sel && bus_priv && bus_write && bus_addr == ADDR_PENDING_CLEAR)
		|=> (st_q.pending & $past(bus_wdata[NUM_IRQ-1:0])
			& ~$past(irq_req)) == '0)
		else $error("pending clear left a bit set");

	// an accepted offer must have been enabled when taken
	a_taken_enabled: assert property (@(posedge clk) disable iff (!resetn)
		(st_q.core == CORE_TAKE && core_ack && st_d.core == CORE_BUSY)
		|-> st_d.enable[st_q.cur_id])
		else $error("disabled interrupt made active");

endmodule

// >>> sim/core_model.sv
// core-side partner that takes offered interrupts and ends handlers
`timescale 1ns/10ps
module core_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic irq_take,
	input wire logic take_en,
	input wire logic finish_en,
	input wire logic [3:0] lat,
	output logic core_ack,
	output logic core_done
);
	logic [3:0] wait_q;
	logic busy_q;

	// ==========================================================
	// take an offer after lat cycles, end the handler when allowed;
	// the ack guard stops a second take while the offer drops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_q <= 4'h0;
			busy_q <= 1'b0;
			core_ack <= 1'b0;
			core_done <= 1'b0;
		end else begin
			core_ack <= 1'b0;
			core_done <= 1'b0;
			if (irq_take && take_en && !busy_q && !core_ack) begin
				wait_q <= (wait_q == lat) ? 4'h0 : wait_q + 4'h1;
				core_ack <= (wait_q == lat);
				busy_q <= (wait_q == lat);
			end else if (busy_q && finish_en && !core_ack) begin
				core_done <= 1'b1;
				busy_q <= 1'b0;
			end else begin
				wait_q <= 4'h0;
			end
		end
	end
endmodule

// >>> sim/tb_vectored_irq_enable_pending_bank.sv
// testbench of the interrupt enable, pending and priority bank
`timescale 1ns/10ps
module tb_vectored_irq_enable_pending_bank;
	import irq_ctrl_pkg::*;
	logic clk, resetn, bus_sel, bus_write, bus_priv, core_ack, core_done;
	logic [NUM_IRQ-1:0] irq_req;
	logic [31:0] bus_addr, bus_wdata, bus_rdata;
	logic [GROUP_W-1:0] group_sel;
	logic bus_hit, irq_take, take_en, finish_en;
	logic [ID_W-1:0] irq_id;
	logic [PRIO_W-1:0] irq_prio;
	logic [3:0] lat;
	int miscompares, check_count, cyc;

	irq_enable_pending_bank dut_u (.clk(clk), .resetn(resetn),
		.irq_req(irq_req), .bus_sel(bus_sel), .bus_write(bus_write),
		.bus_priv(bus_priv), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.group_sel(group_sel), .core_ack(core_ack), .core_done(core_done),
		.bus_rdata(bus_rdata), .bus_hit(bus_hit), .irq_take(irq_take),
		.irq_id(irq_id), .irq_prio(irq_prio));
	core_model core_u (.clk(clk), .resetn(resetn), .irq_take(irq_take),
		.take_en(take_en), .finish_en(finish_en), .lat(lat),
		.core_ack(core_ack), .core_done(core_done));

	// ==========================================================
	// clock, and a ceiling well above the couple of hundred cycles used
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// shared checks and bus cycles
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle strobe; answer is looked at in the cycle after it
	task automatic acc(input logic w, input logic p,
		input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_sel <= 1'b1;
		bus_write <= w;
		bus_priv <= p;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_sel <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		acc(1'b1, 1'b1, a, d);
		chk({31'h0, bus_hit}, 32'h1);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		acc(1'b0, 1'b1, a, 32'h0);
		chk({31'h0, bus_hit}, 32'h1);
		chk(bus_rdata, e);
	endtask
	task automatic wait_take(input logic v);
		int n;
		n = 0;
		while (irq_take !== v && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({31'h0, irq_take}, {31'h0, v});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		rd(ADDR_ENABLE_SET, 32'h0);
		rd(ADDR_PENDING_CLEAR, 32'h0);
		rd(ADDR_ACTIVE_STATUS, 32'h0);
		for (int i = 0; i < NUM_PRIO_REGS; i++) begin
			rd(ADDR_PRIO_BASE + 32'(4 * i), 32'h0);
		end
		$display("test reset done");
	endtask
	task automatic t_enable;
		wr(ADDR_ENABLE_SET, 32'hFFFFFFFF);
		rd(ADDR_ENABLE_SET, 32'h3FFFFFFF);
		wr(ADDR_ENABLE_CLEAR, 32'h0);
		rd(ADDR_ENABLE_CLEAR, 32'h3FFFFFFF);
		wr(ADDR_ENABLE_CLEAR, 32'h00000001);
		rd(ADDR_ENABLE_SET, 32'h3FFFFFFE);
		wr(ADDR_ENABLE_SET, 32'h0);
		rd(ADDR_ENABLE_SET, 32'h3FFFFFFE);
		wr(ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
		rd(ADDR_ENABLE_CLEAR, 32'h0);
		$display("test enable done");
	endtask
	// all lines disabled, so nothing may ever be offered
	task automatic t_pending;
		wr(ADDR_PENDING_SET, 32'hC0000005);
		rd(ADDR_PENDING_SET, 32'h5);
		wr(ADDR_PENDING_SET, 32'h5);
		rd(ADDR_PENDING_CLEAR, 32'h5);
		wr(ADDR_PENDING_CLEAR, 32'h4);
		rd(ADDR_PENDING_SET, 32'h1);
		acc(1'b1, 1'b1, ADDR_SOFT_TRIGGER, 32'h7);
		rd(ADDR_PENDING_SET, 32'h81);
		irq_req <= 30'h0000009;
		rd(ADDR_PENDING_SET, 32'h89);
		irq_req <= '0;
		chk({31'h0, irq_take}, 32'h0);
		wr(ADDR_PENDING_CLEAR, 32'hFFFFFFFF);
		rd(ADDR_PENDING_SET, 32'h0);
		$display("test pending done");
	endtask
	task automatic t_priv;
		acc(1'b1, 1'b0, ADDR_ENABLE_SET, 32'hFFFFFFFF);
		chk({31'h0, bus_hit}, 32'h0);
		acc(1'b0, 1'b1, 32'hE000E104, 32'h0);
		chk({31'h0, bus_hit}, 32'h0);
		rd(ADDR_ENABLE_SET, 32'h0);
		$display("test privilege done");
	endtask
	// irq 5 level 2 and irq 9 level 1, then irq 5 raised to level 0
	task automatic t_arb;
		wr(ADDR_PRIO_BASE + 32'h4, 32'h00000200);
		wr(ADDR_PRIO_BASE + 32'h8, 32'h00000100);
		rd(ADDR_PRIO_BASE + 32'h8, 32'h00000100);
		wr(ADDR_PENDING_SET, 32'h220);
		wr(ADDR_ENABLE_SET, 32'h220);
		wait_take(1'b1);
		chk({27'h0, irq_id}, 32'h9);
		chk({28'h0, irq_prio}, 32'h1);
		wr(ADDR_PRIO_BASE + 32'h4, 32'h0);
		repeat (3) @(posedge clk);
		#1;
		chk({27'h0, irq_id}, 32'h5);
		take_en <= 1'b1;
		wait_take(1'b0);
		rd(ADDR_ACTIVE_STATUS, 32'h20);
		rd(ADDR_PENDING_SET, 32'h200);
		wr(ADDR_PENDING_SET, 32'h20);
		rd(ADDR_ACTIVE_STATUS, 32'h20);
		wr(ADDR_PENDING_CLEAR, 32'h20);
		rd(ADDR_ACTIVE_STATUS, 32'h20);
		finish_en <= 1'b1;
		repeat (30) @(posedge clk);
		rd(ADDR_ACTIVE_STATUS, 32'h0);
		rd(ADDR_PENDING_SET, 32'h0);
		$display("test arbitration done");
	endtask

	// ==========================================================
	// verdict
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		irq_req = '0;
		bus_sel = 1'b0;
		bus_write = 1'b0;
		bus_priv = 1'b0;
		bus_addr = 32'h0;
		bus_wdata = 32'h0;
		group_sel = GROUP_RESET;
		take_en = 1'b0;
		finish_en = 1'b0;
		lat = 4'h2;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_enable();
		t_pending();
		t_priv();
		t_arb();
		tally_and_finish();
	end
endmodule
